// ===== src/output_terminal_function_select.sv
// Purpose: Chooses what the multi-purpose output terminal reports
// Assumes: Drive status arrives on clk_sys from the drive core
// Notes: Digital level and analog value both come straight from flops
//
// How it works
// - Band upper edge is centre plus half width
// - Skip bands mirror onto negative speeds
// - Selector takes codes 0 to 12, resets 8
// - Digital codes drive a logic level
// - Code 0: high while drive running
// - Code 1: high while no fault present
// - Code 2: high when frequency equals setpoint
// - Code 3: high when speed nonzero in either direction
// - Code 10: torque scaled over 200 percent
// - Code 11: power scaled over 150 percent
// - Code 12: PID output scaled over 100 percent
// - Band lower edge is centre minus half width
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "oterm_map.svh"

module output_terminal_function_select (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Drive status from the drive core
  input wire oterm_pkg::drive_status_t drive_status,
  // Terminal output stage
  output logic term_level_r,
  output logic analog_mode_r,
  output logic [15:0] analog_value_r,
  // Skip band edges for the speed ramp
  output oterm_pkg::skip_band_t skip_band_r
);

  // ==========================================================================
  // State and reset image
  oterm_pkg::state_t st_r;
  oterm_pkg::state_t st_nxt;
  oterm_pkg::skip_band_t band_calc;

  localparam oterm_pkg::state_t ST_RST = '{
    func_sel: `OT_FUNC_SEL_RST,
    centre: `OT_CENTRE_RST,
    width: `OT_WIDTH_RST,
    max_speed: `OT_MAX_SPEED_RST,
    speed_limit: `OT_SPEED_LIMIT_RST,
    rated_current: `OT_RATED_CURRENT_RST,
    term_level: 1'b0,
    analog_mode: 1'b0,
    analog_value: 16'h0000,
    band: '0,
    rdata: 32'h0000_0000
  };

  // ==========================================================================
  // Linear scaling to the analog full scale
  // Saturates at full scale; a zero span gives full scale for any nonzero input,
  // so a forgotten rating shows up as a pinned output rather than a silent zero.
  function automatic logic [15:0] scale(input logic [16:0] num, input logic [16:0] den);
    logic [32:0] prod;
    logic [32:0] quot;
    begin
      prod = 33'(num) * 33'(`OT_ANALOG_MAX);
      quot = 33'h0;
      if (den == 17'h0)
      begin
        scale = (num == 17'h0) ? 16'h0000 : `OT_ANALOG_MAX;
      end
      else
      begin
        quot = prod / 33'(den);
        scale = (quot > 33'(`OT_ANALOG_MAX)) ? `OT_ANALOG_MAX : quot[15:0];
      end
    end
  endfunction

  // ==========================================================================
  // Skip band edges
  skip_band_calc u_band (
    .centre(st_r.centre),
    .width(st_r.width),
    .band(band_calc)
  );

  // ==========================================================================
  // Speed magnitude; seventeen bits so the most negative speed does not wrap
  logic [16:0] speed_mag;
  logic [16:0] current_span;

  assign speed_mag = drive_status.motor_speed[15] ?
    17'(-{drive_status.motor_speed[15], drive_status.motor_speed}) :
    {1'b0, drive_status.motor_speed};
  // Current full scale is twice the rated current
  assign current_span = {st_r.rated_current, 1'b0};

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = 32'h0000_0000;

    // Register writes
    if (reg_wr)
    begin
      case (reg_addr)
        `OT_ADDR_FUNC_SEL:
        begin
          // Codes beyond the top of the range are dropped, old code kept
          if (reg_wdata[31:4] == 28'h0 && reg_wdata[3:0] <= `OT_FUNC_SEL_MAX)
          begin
            st_nxt.func_sel = reg_wdata[3:0];
          end
        end
        `OT_ADDR_CENTRE:
        begin
          st_nxt.centre = reg_wdata[15:0];
        end
        `OT_ADDR_WIDTH:
        begin
          st_nxt.width = reg_wdata[15:0];
        end
        `OT_ADDR_MAX_SPEED:
        begin
          st_nxt.max_speed = reg_wdata[15:0];
        end
        `OT_ADDR_SPEED_LIMIT:
        begin
          st_nxt.speed_limit = reg_wdata[15:0];
        end
        `OT_ADDR_RATED_CURRENT:
        begin
          st_nxt.rated_current = reg_wdata[15:0];
        end
        default:
        begin
          st_nxt.func_sel = st_r.func_sel; // Read-only and unmapped writes ignored
        end
      endcase
    end

    // Register reads, answered in the next cycle only
    if (reg_rd)
    begin
      case (reg_addr)
        `OT_ADDR_FUNC_SEL:
        begin
          st_nxt.rdata = {28'h0, st_r.func_sel};
        end
        `OT_ADDR_CENTRE:
        begin
          st_nxt.rdata = {16'h0, st_r.centre};
        end
        `OT_ADDR_WIDTH:
        begin
          st_nxt.rdata = {16'h0, st_r.width};
        end
        `OT_ADDR_MAX_SPEED:
        begin
          st_nxt.rdata = {16'h0, st_r.max_speed};
        end
        `OT_ADDR_SPEED_LIMIT:
        begin
          st_nxt.rdata = {16'h0, st_r.speed_limit};
        end
        `OT_ADDR_RATED_CURRENT:
        begin
          st_nxt.rdata = {16'h0, st_r.rated_current};
        end
        `OT_ADDR_STATUS:
        begin
          st_nxt.rdata = {16'h0, st_r.analog_value};
          st_nxt.rdata[`OT_STAT_LEVEL_BIT] = st_r.term_level;
          st_nxt.rdata[`OT_STAT_ANALOG_BIT] = st_r.analog_mode;
        end
        `OT_ADDR_SKIP_FWD:
        begin
          st_nxt.rdata = {st_r.band.hi_fwd[15:0], st_r.band.lo_fwd[15:0]};
        end
        `OT_ADDR_SKIP_REV:
        begin
          st_nxt.rdata = {st_r.band.hi_rev[15:0], st_r.band.lo_rev[15:0]};
        end
        default:
        begin
          st_nxt.rdata = 32'h0000_0000; // Unmapped reads as zero
        end
      endcase
    end

    // Terminal source, refreshed every cycle from the live status
    st_nxt.term_level = 1'b0;
    st_nxt.analog_mode = 1'b0;
    st_nxt.analog_value = 16'h0000;
    case (st_r.func_sel)
      oterm_pkg::FN_RUNNING:
      begin
        st_nxt.term_level = drive_status.running;
      end
      oterm_pkg::FN_HEALTHY:
      begin
        st_nxt.term_level = ~drive_status.fault;
      end
      oterm_pkg::FN_AT_SPEED:
      begin
        st_nxt.term_level = (drive_status.out_freq == drive_status.setpoint_freq);
      end
      oterm_pkg::FN_SPEED_NZ:
      begin
        st_nxt.term_level = (speed_mag != 17'h0);
      end
      oterm_pkg::FN_SPEED_LIMIT:
      begin
        st_nxt.term_level = (speed_mag >= {1'b0, st_r.speed_limit});
      end
      oterm_pkg::FN_AN_SPEED:
      begin
        st_nxt.analog_mode = 1'b1;
        st_nxt.analog_value = scale(speed_mag, {1'b0, st_r.max_speed});
      end
      oterm_pkg::FN_AN_CURRENT:
      begin
        st_nxt.analog_mode = 1'b1;
        st_nxt.analog_value = scale({1'b0, drive_status.motor_current}, current_span);
      end
      oterm_pkg::FN_AN_TORQUE:
      begin
        st_nxt.analog_mode = 1'b1;
        st_nxt.analog_value = scale({1'b0, drive_status.motor_torque}, `OT_TORQUE_FS);
      end
      oterm_pkg::FN_AN_POWER:
      begin
        st_nxt.analog_mode = 1'b1;
        st_nxt.analog_value = scale({1'b0, drive_status.motor_power}, `OT_POWER_FS);
      end
      oterm_pkg::FN_AN_PID:
      begin
        st_nxt.analog_mode = 1'b1;
        st_nxt.analog_value = scale({1'b0, drive_status.pid_output}, `OT_PID_FS);
      end
      default:
      begin
        st_nxt.term_level = 1'b0;
      end
    endcase

    // Band edges follow the settings one cycle later
    st_nxt.band = band_calc;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_r <= ST_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state flops
  assign reg_rdata = st_r.rdata;
  assign term_level_r = st_r.term_level;
  assign analog_mode_r = st_r.analog_mode;
  assign analog_value_r = st_r.analog_value;
  assign skip_band_r = st_r.band;

endmodule

`default_nettype wire

// ===== src/oterm_map.svh
// Purpose: Register offsets, reset values and scaling constants of the output terminal selector
// Assumes: Byte addresses on an 8-bit register port with 32-bit data
// Notes: Definitions only
`ifndef OTERM_MAP_SVH
`define OTERM_MAP_SVH

// ==========================================================================
// Register byte offsets
`define OT_ADDR_FUNC_SEL 8'h00
`define OT_ADDR_CENTRE 8'h04
`define OT_ADDR_WIDTH 8'h08
`define OT_ADDR_MAX_SPEED 8'h0c
`define OT_ADDR_SPEED_LIMIT 8'h10
`define OT_ADDR_RATED_CURRENT 8'h14
`define OT_ADDR_STATUS 8'h18
`define OT_ADDR_SKIP_FWD 8'h1c
`define OT_ADDR_SKIP_REV 8'h20

// ==========================================================================
// Reset values and the top selector code
`define OT_FUNC_SEL_RST 4'h8
`define OT_FUNC_SEL_MAX 4'hc
`define OT_CENTRE_RST 16'h0000
`define OT_WIDTH_RST 16'h0000
`define OT_MAX_SPEED_RST 16'h01f4
`define OT_SPEED_LIMIT_RST 16'h0000
`define OT_RATED_CURRENT_RST 16'h0000

// ==========================================================================
// Status word field positions
`define OT_STAT_LEVEL_BIT 16
`define OT_STAT_ANALOG_BIT 17

// ==========================================================================
// Analog full-scale figures, inputs in tenths of a percent
`define OT_TORQUE_FS 17'h007d0
`define OT_POWER_FS 17'h005dc
`define OT_PID_FS 17'h003e8
`define OT_ANALOG_MAX 16'hffff

`endif

// ===== src/oterm_pkg.sv
// Purpose: Types shared by the output terminal selector and its skip band helper
// Assumes: Constants come from oterm_map.svh
// Notes: Nothing here holds state
package oterm_pkg;

  // ==========================================================================
  // Selector codes of the output terminal
  typedef enum logic [3:0] {
    FN_RUNNING = 4'h0,
    FN_HEALTHY = 4'h1,
    FN_AT_SPEED = 4'h2,
    FN_SPEED_NZ = 4'h3,
    FN_SPEED_LIMIT = 4'h4,
    FN_AN_SPEED = 4'h8,
    FN_AN_CURRENT = 4'h9,
    FN_AN_TORQUE = 4'ha,
    FN_AN_POWER = 4'hb,
    FN_AN_PID = 4'hc
  } func_code_t;

  // ==========================================================================
  // Drive status from the drive core, same clock
  typedef struct packed {
    logic running;
    logic fault;
    logic [15:0] out_freq;
    logic [15:0] setpoint_freq;
    logic signed [15:0] motor_speed;
    logic [15:0] motor_current;
    logic [15:0] motor_torque;
    logic [15:0] motor_power;
    logic [15:0] pid_output;
  } drive_status_t;

  // Skip band limits, forward and mirrored
  typedef struct packed {
    logic signed [17:0] lo_fwd;
    logic signed [17:0] hi_fwd;
    logic signed [17:0] lo_rev;
    logic signed [17:0] hi_rev;
  } skip_band_t;

  // ==========================================================================
  // Whole state of the selector
  typedef struct packed {
    logic [3:0] func_sel;
    logic [15:0] centre;
    logic [15:0] width;
    logic [15:0] max_speed;
    logic [15:0] speed_limit;
    logic [15:0] rated_current;
    logic term_level;
    logic analog_mode;
    logic [15:0] analog_value;
    skip_band_t band;
    logic [31:0] rdata;
  } state_t;

endpackage

// ===== src/skip_band_calc.sv
// Purpose: Works out the skip band edges from centre and width
// Assumes: Centre and width are unsigned speed words
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ns
`default_nettype none

module skip_band_calc (
  // Band settings
  input wire logic [15:0] centre,
  input wire logic [15:0] width,
  // Band edges
  output oterm_pkg::skip_band_t band
);

  logic signed [17:0] half_w;
  logic signed [17:0] ctr;

  // ==========================================================================
  // Edges; eighteen bits so a wide band below zero keeps its sign
  assign half_w = signed'({3'h0, width[15:1]});
  assign ctr = signed'({2'h0, centre});
  assign band.lo_fwd = ctr - half_w;
  assign band.hi_fwd = ctr + half_w;
  // Reverse band is the forward band turned about zero
  assign band.lo_rev = -(ctr + half_w);
  assign band.hi_rev = -(ctr - half_w);

endmodule

`default_nettype wire

// ===== test/oterm_stage.sv
// Purpose: Behavioural model of the terminal output stage
// Assumes: Levels come straight from the selector's flops
// Notes: Gives the pin level in millivolts, 0 to 10 V analog
`timescale 1ns/1ns
`default_nettype none

module oterm_stage (
  // From the selector
  input wire logic term_level_r,
  input wire logic analog_mode_r,
  input wire logic [15:0] analog_value_r,
  // Pin level
  output logic [15:0] pin_mv
);
  // ==========================================
  // Analog spans 10 V; digital one is 24 V
  always_comb
  begin
    if (analog_mode_r)
      pin_mv = 16'((32'(analog_value_r) * 32'h2710) / 32'hffff);
    else
      pin_mv = term_level_r ? 16'h5dc0 : 16'h0000;
  end
endmodule

`default_nettype wire

// ===== test/oterm_chk_sva.sv
// Purpose: Assertions on the output terminal selector ports
// Assumes: Shadows of the settings follow accepted writes
// Notes: Bound to every instance of the selector
`timescale 1ns/1ns
`default_nettype none

module oterm_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Status and terminal
  input wire oterm_pkg::drive_status_t drive_status,
  input wire logic term_level_r,
  input wire logic analog_mode_r,
  input wire logic [15:0] analog_value_r,
  input wire oterm_pkg::skip_band_t skip_band_r
);
  logic [3:0] sel_q;
  logic [15:0] cen_q, wid_q, thr_q, num;
  logic [31:0] den;
  logic [16:0] mag;

  // ==========================================
  // Shadows; codes above 12 never land
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      sel_q <= 4'h8;
      cen_q <= 16'h0000;
      wid_q <= 16'h0000;
      thr_q <= 16'h0000;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 8'h00 && reg_wdata <= 32'h0000000c) sel_q <= reg_wdata[3:0];
      if (reg_addr == 8'h04) cen_q <= reg_wdata[15:0];
      if (reg_addr == 8'h08) wid_q <= reg_wdata[15:0];
      if (reg_addr == 8'h10) thr_q <= reg_wdata[15:0];
    end
  end

  // Source and span of the analog codes; magnitude copes with the most negative speed
  assign num = sel_q == 4'ha ? drive_status.motor_torque :
               sel_q == 4'hb ? drive_status.motor_power : drive_status.pid_output;
  assign den = sel_q == 4'ha ? 32'h7d0 : sel_q == 4'hb ? 32'h5dc : 32'h3e8;
  assign mag = drive_status.motor_speed[15] ? 17'h10000 - {1'b0, drive_status.motor_speed}
                                            : {1'b0, drive_status.motor_speed};

  function automatic logic [15:0] scl(input logic [15:0] n, input logic [31:0] d);
    logic [47:0] q;
    q = (48'(n) * 48'hffff) / 48'(d);
    return q > 48'hffff ? 16'hffff : q[15:0];
  endfunction

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  chk_sel_readback: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == {28'h0, $past(sel_q)})
    else $error("selector readback wrong");
  chk_run_level: assert property (sel_q == 4'h0 |=> term_level_r == $past(drive_status.running))
    else $error("running level wrong");
  chk_healthy_level: assert property (sel_q == 4'h1 |=> term_level_r == !$past(drive_status.fault))
    else $error("healthy level wrong");
  chk_at_speed: assert property (sel_q == 4'h2 |=> term_level_r ==
    ($past(drive_status.out_freq) == $past(drive_status.setpoint_freq)))
    else $error("at speed level wrong");
  chk_speed_nz: assert property (sel_q == 4'h3 |=> term_level_r == ($past(drive_status.motor_speed) != 0))
    else $error("nonzero speed level wrong");
  chk_speed_limit: assert property (sel_q == 4'h4 |=> term_level_r == ($past(mag) >= {1'b0, $past(thr_q)}))
    else $error("speed limit level wrong");
  chk_unused_zero: assert property (sel_q inside {4'h5, 4'h6, 4'h7} |=>
    !term_level_r && !analog_mode_r && analog_value_r == 16'h0000)
    else $error("unused code not quiet");
  chk_analog_mode: assert property (sel_q >= 4'h8 |=> analog_mode_r && !term_level_r)
    else $error("analog mode flag wrong");
  chk_analog_scale: assert property (sel_q inside {4'ha, 4'hb, 4'hc} |=>
    analog_value_r == scl($past(num), $past(den)))
    else $error("analog scaling wrong");
  chk_band_upper: assert property (1'b1 |=> skip_band_r.hi_fwd == 18'($past(cen_q)) + 18'($past(wid_q) >> 1))
    else $error("band upper edge wrong");
  chk_band_lower: assert property (1'b1 |=> skip_band_r.lo_fwd == 18'($past(cen_q)) - 18'($past(wid_q) >> 1))
    else $error("band lower edge wrong");
  chk_band_mirror: assert property (skip_band_r.lo_rev == -skip_band_r.hi_fwd &&
    skip_band_r.hi_rev == -skip_band_r.lo_fwd)
    else $error("band mirror wrong");

  cover property (sel_q == 4'h0 && drive_status.running);
  cover property (sel_q == 4'ha && num != 16'h0000);
  cover property (reg_wr && reg_addr == 8'h08);
endmodule

bind output_terminal_function_select oterm_chk oterm_chk_i (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .drive_status, .term_level_r, .analog_mode_r, .analog_value_r, .skip_band_r);

`default_nettype wire

// ===== test/tb.sv
// Purpose: Self-checking bench for the output terminal selector
// Assumes: Register port answers one cycle after a read strobe
// Notes: Expectations are computed here from the selector codes
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  oterm_pkg::drive_status_t ds = '0;
  oterm_pkg::drive_status_t st [3];
  logic term_level_r, analog_mode_r;
  logic [15:0] analog_value_r, pin_mv, nv;
  oterm_pkg::skip_band_t skip_band_r;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int c, i, h;
  int cen [2] = '{1000, 50};
  int wid [2] = '{201, 200};

  output_terminal_function_select output_terminal_function_select_i (.clk_sys, .srst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .drive_status(ds), .term_level_r, .analog_mode_r,
    .analog_value_r, .skip_band_r);
  oterm_stage oterm_stage_i (.term_level_r, .analog_mode_r, .analog_value_r, .pin_mv);

  // ==========================================
  // Clock and hang guard; 4000 cycles is about thirty times the sequence
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      results();
    end
  end

  // ==========================================
  // Access tasks and checks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  function automatic logic lvl(input int k, input oterm_pkg::drive_status_t s);
    case (k)
      0: return s.running;
      1: return !s.fault;
      2: return s.out_freq == s.setpoint_freq;
      3: return s.motor_speed != 0;
      4: return (s.motor_speed < 0 ? -int'(s.motor_speed) : int'(s.motor_speed)) >= 300;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] scl(input logic [15:0] n, input int k);
    longint q;
    q = longint'(n) * 65535 / (k == 10 ? 2000 : k == 11 ? 1500 : 1000);
    return q > 65535 ? 16'hffff : 16'(q);
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    st[0] = '{running:1'b1, out_freq:16'h0064, setpoint_freq:16'h0064, motor_speed:16'hfed4, default:'0};
    st[1] = '{fault:1'b1, out_freq:16'h0065, setpoint_freq:16'h0064, default:'0};
    st[2] = '{running:1'b1, fault:1'b1, out_freq:16'h0005, setpoint_freq:16'h0005, motor_speed:16'h012b,
              default:'0};
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    rd(8'h00, 32'h8);
    chk(analog_mode_r, 32'h1);
    rd(8'h40, 32'h0);
    wr(8'h00, 32'hd);
    rd(8'h00, 32'h8);
    wr(8'h00, 32'hc);
    rd(8'h00, 32'hc);
    $display("test selector done");
    // Threshold sits exactly on one speed magnitude of the table
    wr(8'h10, 32'h12c);
    for (c = 0; c < 8; c++)
    begin
      wr(8'h00, 32'(c));
      for (i = 0; i < 3; i++)
      begin
        @(posedge clk_sys) ds <= st[i];
        @(posedge clk_sys);
        #1 chk(term_level_r, lvl(c, st[i]));
        chk(analog_value_r, 32'h0);
        chk(pin_mv, lvl(c, st[i]) ? 32'h5dc0 : 32'h0);
      end
    end
    $display("test digital done");
    for (c = 10; c < 13; c++)
    begin
      wr(8'h00, 32'(c));
      for (i = 0; i < 2; i++)
      begin
        nv = i == 0 ? 16'h03e8 : 16'h0640;
        @(posedge clk_sys) ds <= '{motor_torque:nv, motor_power:nv, pid_output:nv, default:'0};
        @(posedge clk_sys);
        #1 chk(analog_value_r, scl(nv, c));
        chk(term_level_r, 32'h0);
      end
    end
    // Code 9 spans twice the rating; code 8 spans the reset maximum speed of 500
    wr(8'h14, 32'h64);
    wr(8'h00, 32'h9);
    @(posedge clk_sys) ds <= '{motor_current:16'h0096, motor_speed:16'hfed4, default:'0};
    @(posedge clk_sys);
    #1 chk(analog_value_r, 32'hbfff);
    wr(8'h00, 32'h8);
    @(posedge clk_sys);
    #1 chk(analog_value_r, 32'h9999);
    rd(8'h18, 32'h0002_9999);
    $display("test analog done");
    for (i = 0; i < 2; i++)
    begin
      h = wid[i] / 2;
      wr(8'h04, 32'(cen[i]));
      wr(8'h08, 32'(wid[i]));
      @(posedge clk_sys);
      #1 chk(32'(skip_band_r.hi_fwd), 32'(cen[i] + h));
      chk(32'(skip_band_r.lo_fwd), 32'(cen[i] - h));
      chk(32'(skip_band_r.lo_rev), 32'(-cen[i] - h));
      chk(32'(skip_band_r.hi_rev), 32'(h - cen[i]));
      rd(8'h1c, {16'(cen[i] + h), 16'(cen[i] - h)});
      rd(8'h20, {16'(h - cen[i]), 16'(-cen[i] - h)});
    end
    $display("test band done");
    results();
  end
endmodule

`default_nettype wire
